//--- sod_pkg.sv
package sod_pkg;
  // Prefix byte of a two-byte memory code
  localparam logic [7:0] PFX_21 = 8'h21;
  // Decoded operation classes
  typedef enum logic [5:0] {
    SOD_NONE,
    SOD_BLOCK2D_SETUP, SOD_BLOCK2D_COPY_ALL, SOD_BLOCK2D_COPY_NONZERO_BYTES, SOD_BLOCK2D_COPY_ZERO_BYTES,
    SOD_CRC_WORD, SOD_CRC_BYTE, SOD_BIT_COUNT, SOD_BIT_REV_WORD, SOD_BIT_REV_NBITS,
    SOD_FP_CHECK_ERR, SOD_FP_TEST_ERR, SOD_FP_UNPACK, SOD_FP_ROUND, SOD_FP_POSTNORM,
    SOD_RANGE_SIGNED, SOD_RANGE_UNSIGNED, SOD_BYTE_RANGE_CHECK, SOD_BYTE_RANGE_CHECK_U,
    SOD_HALF_RANGE_CHECK, SOD_HALF_RANGE_CHECK_U, SOD_SEXT_HALF, SOD_SEXT_BYTE,
    SOD_HALF_SUBSCRIPT, SOD_HALFWORD_LOAD, SOD_HALF_STORE, SOD_LOAD_BYTE_SX, SOD_LOAD_HALF_SX,
    SOD_DEV_LOAD_BYTE, SOD_DEV_LOAD_HALF, SOD_DEV_LOAD_WORD, SOD_DEV_STORE_BYTE,
    SOD_DEV_STORE_HALF, SOD_DEV_STORE_WORD, SOD_DEV_BLOCK,
    SOD_Q_SWAP, SOD_Q_SWAP_TIMER, SOD_Q_INSERT, SOD_TIMESLICE, SOD_RESTART, SOD_CAUSE_ERR,
    SOD_TRAP_LOAD_HANDLER, SOD_TRAP_LOAD_PROC, SOD_TRAP_STORE_PROC, SOD_TRAP_STORE_HANDLER,
    SOD_TRAP_ENABLE, SOD_TRAP_DISABLE, SOD_TRAP_RETURN
  } sod_op_t;
  // Cycle counts; zero means data dependent (unbounded by the table)
  localparam logic [5:0] CYC_CRC_WORD = 6'h22;
  localparam logic [5:0] CYC_CRC_BYTE = 6'h0a;
  localparam logic [5:0] CYC_TRAP_LS  = 6'h0b;
  localparam logic [5:0] CYC_RESTART  = 6'h13;
  localparam logic [5:0] CYC_TRET     = 6'h09;
  // Address layout
  localparam int ADDR_W     = 32;
  localparam int WORD_W     = 30;
  localparam int BSEL_W     = 2;
  localparam int PIN_ADDR_W = 20;
  localparam logic [2:0] PERIPH_TOP = 3'h1;
endpackage

//--- sod_addr_split.sv
`timescale 1ns/1ps
`default_nettype none
module sod_addr_split
  import sod_pkg::*;
(
  // Address in
  input  wire logic [31:0] addr,
  input  wire logic        dev_access,
  // Fields out
  output logic [29:0]      word_addr,
  output logic [1:0]       byte_sel,
  output logic [1:0]       bank,
  output logic [19:0]      pin_addr,
  output logic             to_periph
);
  assign word_addr = addr[31:2];
  assign byte_sel  = addr[1:0];
  assign bank      = addr[31:30];
  // bits 20 to 29 never leave the chip
  assign pin_addr  = addr[19:0];
  // device access to upper half of bank zero
  assign to_periph = dev_access && (addr[31:29] == PERIPH_TOP);
endmodule
`default_nettype wire

//--- sod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Codes 25FB..25FE decode to block setup (1 cycle) and the three 2D copies.
// - Code 27F4 is a word CRC of 34 cycles and 27F5 a byte CRC of 10 cycles.
// - Code 27F6 counts one bits in 3 cycles.
// - Code 27F7 reverses the word in 1 cycle and 27F8 the low n bits in 2 cycles.
// - Float unpack 26F3 is 4 cycles, round 26FD 7, post-normalize 26FC 7 to 8.
// - Code 27F3 checks float error in 2 cycles and 29FC pushes true as no FPU exists.
// - Range checks 2CF7/2CFC take 2 to 4 cycles, byte and halfword checks 2 to 3.
// - Code 2FF8 sign-extends a halfword in 2 cycles and 2BF8 a byte in 3.
// - Codes 2CF1, 2CFA, 2BF9, 2FF9 take 1 cycle and 2CF8 takes 2.
// - Device loads and stores 2FF0..2FF5 take 3 cycles and 62F4 is device block move.
// - Scheduler codes 60F0..60F3, 62FE, 62FF take 3, 5, 1-2, 3-4, 19 and 2 cycles.
// - Trap load/store codes take 11 cycles, enable/disable 2 and return 9.
// - Addresses are signed 32-bit, split into 30-bit word and 2-bit byte select.
// - Four banks are selected by the two top address bits.
// - Address bits 20 to 29 are kept internally but not driven to pins.
// - Device access to upper half of bank zero reaches peripherals, all else goes to memory.
module sod_decoder
  import sod_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Instruction bytes from fetch
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  // Operand address
  input  wire logic [31:0] op_addr,
  // Decoded issue
  output sod_pkg::sod_op_t op_q,
  output logic             issue_q,
  output logic [5:0]       cyc_min_q,
  output logic [5:0]       cyc_max_q,
  output logic             fp_true_q,
  // Address fields
  output logic [29:0]      word_addr_q,
  output logic [1:0]       byte_sel_q,
  output logic [1:0]       bank_q,
  output logic [19:0]      pin_addr_q,
  output logic             to_periph_q,
  output logic             to_ext_q
);
  import sod_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Decode table
  function automatic logic [17:0] lookup(input logic [15:0] code);
    sod_op_t o;
    logic [5:0] mn;
    logic [5:0] mx;
    o = SOD_NONE;
    mn = 6'h00;
    mx = 6'h00;
    case (code)
      16'h25fb: begin o = SOD_BLOCK2D_SETUP; mn = 6'h01; mx = 6'h01; end
      16'h25fc: o = SOD_BLOCK2D_COPY_ALL;
      16'h25fd: o = SOD_BLOCK2D_COPY_NONZERO_BYTES;
      16'h25fe: o = SOD_BLOCK2D_COPY_ZERO_BYTES;
      16'h27f4: begin o = SOD_CRC_WORD; mn = CYC_CRC_WORD; mx = CYC_CRC_WORD; end
      16'h27f5: begin o = SOD_CRC_BYTE; mn = CYC_CRC_BYTE; mx = CYC_CRC_BYTE; end
      16'h27f6: begin o = SOD_BIT_COUNT; mn = 6'h03; mx = 6'h03; end
      16'h27f7: begin o = SOD_BIT_REV_WORD; mn = 6'h01; mx = 6'h01; end
      16'h27f8: begin o = SOD_BIT_REV_NBITS; mn = 6'h02; mx = 6'h02; end
      16'h26f3: begin o = SOD_FP_UNPACK; mn = 6'h04; mx = 6'h04; end
      16'h26fd: begin o = SOD_FP_ROUND; mn = 6'h07; mx = 6'h07; end
      16'h26fc: begin o = SOD_FP_POSTNORM; mn = 6'h07; mx = 6'h08; end
      16'h27f3: begin o = SOD_FP_CHECK_ERR; mn = 6'h02; mx = 6'h02; end
      16'h29fc: begin o = SOD_FP_TEST_ERR; mn = 6'h01; mx = 6'h01; end
      16'h2cf7: begin o = SOD_RANGE_SIGNED; mn = 6'h02; mx = 6'h04; end
      16'h2cfc: begin o = SOD_RANGE_UNSIGNED; mn = 6'h02; mx = 6'h04; end
      16'h2bfa: begin o = SOD_BYTE_RANGE_CHECK; mn = 6'h02; mx = 6'h03; end
      16'h2bfb: begin o = SOD_BYTE_RANGE_CHECK_U; mn = 6'h02; mx = 6'h03; end
      16'h2ffa: begin o = SOD_HALF_RANGE_CHECK; mn = 6'h02; mx = 6'h03; end
      16'h2ffb: begin o = SOD_HALF_RANGE_CHECK_U; mn = 6'h02; mx = 6'h03; end
      16'h2ff8: begin o = SOD_SEXT_HALF; mn = 6'h02; mx = 6'h02; end
      16'h2bf8: begin o = SOD_SEXT_BYTE; mn = 6'h03; mx = 6'h03; end
      16'h2cf1: begin o = SOD_HALF_SUBSCRIPT; mn = 6'h01; mx = 6'h01; end
      16'h2cfa: begin o = SOD_HALFWORD_LOAD; mn = 6'h01; mx = 6'h01; end
      16'h2cf8: begin o = SOD_HALF_STORE; mn = 6'h02; mx = 6'h02; end
      16'h2bf9: begin o = SOD_LOAD_BYTE_SX; mn = 6'h01; mx = 6'h01; end
      16'h2ff9: begin o = SOD_LOAD_HALF_SX; mn = 6'h01; mx = 6'h01; end
      16'h2ff0: begin o = SOD_DEV_LOAD_BYTE; mn = 6'h03; mx = 6'h03; end
      16'h2ff2: begin o = SOD_DEV_LOAD_HALF; mn = 6'h03; mx = 6'h03; end
      16'h2ff4: begin o = SOD_DEV_LOAD_WORD; mn = 6'h03; mx = 6'h03; end
      16'h2ff1: begin o = SOD_DEV_STORE_BYTE; mn = 6'h03; mx = 6'h03; end
      16'h2ff3: begin o = SOD_DEV_STORE_HALF; mn = 6'h03; mx = 6'h03; end
      16'h2ff5: begin o = SOD_DEV_STORE_WORD; mn = 6'h03; mx = 6'h03; end
      16'h62f4: o = SOD_DEV_BLOCK;
      16'h60f0: begin o = SOD_Q_SWAP; mn = 6'h03; mx = 6'h03; end
      16'h60f1: begin o = SOD_Q_SWAP_TIMER; mn = 6'h05; mx = 6'h05; end
      16'h60f2: begin o = SOD_Q_INSERT; mn = 6'h01; mx = 6'h02; end
      16'h60f3: begin o = SOD_TIMESLICE; mn = 6'h03; mx = 6'h04; end
      16'h62fe: begin o = SOD_RESTART; mn = CYC_RESTART; mx = CYC_RESTART; end
      16'h62ff: begin o = SOD_CAUSE_ERR; mn = 6'h02; mx = 6'h02; end
      16'h26fe: begin o = SOD_TRAP_LOAD_HANDLER; mn = CYC_TRAP_LS; mx = CYC_TRAP_LS; end
      16'h2cf6: begin o = SOD_TRAP_LOAD_PROC; mn = CYC_TRAP_LS; mx = CYC_TRAP_LS; end
      16'h2cfb: begin o = SOD_TRAP_STORE_PROC; mn = CYC_TRAP_LS; mx = CYC_TRAP_LS; end
      16'h26ff: begin o = SOD_TRAP_STORE_HANDLER; mn = CYC_TRAP_LS; mx = CYC_TRAP_LS; end
      16'h60f7: begin o = SOD_TRAP_ENABLE; mn = 6'h02; mx = 6'h02; end
      16'h60f6: begin o = SOD_TRAP_DISABLE; mn = 6'h02; mx = 6'h02; end
      16'h60fb: begin o = SOD_TRAP_RETURN; mn = CYC_TRET; mx = CYC_TRET; end
      default: o = SOD_NONE;
    endcase
    return {o, mn, mx};
  endfunction

  function automatic logic is_dev(input sod_op_t o);
    return (o == SOD_DEV_LOAD_BYTE) || (o == SOD_DEV_LOAD_HALF) || (o == SOD_DEV_LOAD_WORD) ||
           (o == SOD_DEV_STORE_BYTE) || (o == SOD_DEV_STORE_HALF) || (o == SOD_DEV_STORE_WORD) ||
           (o == SOD_DEV_BLOCK);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Prefix accumulation
  logic [15:0] pfx_q;
  logic [15:0] pfx_d;
  logic [17:0] hit;
  logic [15:0] code;
  sod_op_t     op_d;
  logic        issue_d;
  logic [5:0]  cyc_min_d;
  logic [5:0]  cyc_max_d;

  always_comb begin
    pfx_d     = pfx_q;
    issue_d   = 1'b0;
    code      = {pfx_q[11:0], byte_in[3:0]};
    hit       = 18'h0;
    op_d      = op_q;
    cyc_min_d = cyc_min_q;
    cyc_max_d = cyc_max_q;
    if (byte_valid) begin
      // prefix bytes (function 2 and 6) shift in
      if (byte_in[7:4] == 4'h2 || byte_in[7:4] == 4'h6) begin
        pfx_d = {pfx_q[7:0], byte_in};
      end else begin
        pfx_d     = 16'h0000;
        code      = {pfx_q[7:0], byte_in};
        hit       = lookup(code);
        op_d      = sod_op_t'(hit[17:12]);
        cyc_min_d = hit[11:6];
        cyc_max_d = hit[5:0];
        issue_d   = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pfx_q     <= 16'h0000;
      op_q      <= SOD_NONE;
      issue_q   <= 1'b0;
      cyc_min_q <= 6'h00;
      cyc_max_q <= 6'h00;
    end else begin
      pfx_q     <= pfx_d;
      op_q      <= op_d;
      issue_q   <= issue_d;
      cyc_min_q <= cyc_min_d;
      cyc_max_q <= cyc_max_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result flags and address
  logic        fp_true_d;
  logic [29:0] wa;
  logic [1:0]  bs;
  logic [1:0]  bk;
  logic [19:0] pa;
  logic        per;

  sod_addr_split u_split (
    .addr       (op_addr),
    .dev_access (is_dev(op_d)),
    .word_addr  (wa),
    .byte_sel   (bs),
    .bank       (bk),
    .pin_addr   (pa),
    .to_periph  (per)
  );

  always_comb begin
    fp_true_d = issue_d && (op_d == SOD_FP_TEST_ERR);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fp_true_q   <= 1'b0;
      word_addr_q <= 30'h0;
      byte_sel_q  <= 2'h0;
      bank_q      <= 2'h0;
      pin_addr_q  <= 20'h00000;
      to_periph_q <= 1'b0;
      to_ext_q    <= 1'b0;
    end else begin
      fp_true_q   <= fp_true_d;
      word_addr_q <= wa;
      byte_sel_q  <= bs;
      bank_q      <= bk;
      pin_addr_q  <= pa;
      to_periph_q <= issue_d && per;
      to_ext_q    <= issue_d && !per;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_crc_word_time: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && pfx_q[7:0] == 8'h27 && byte_in == 8'hf4) |=> (issue_q && cyc_max_q == 6'h22))
    else $error("crc word timing wrong");
  chk_bitcnt_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_BIT_COUNT) |-> (cyc_min_q == 6'h03 && cyc_max_q == 6'h03))
    else $error("bit count timing wrong");
  chk_fpu_true: assert property (@(posedge clock) disable iff (rst)
    fp_true_q |-> (op_q == SOD_FP_TEST_ERR && issue_q))
    else $error("fp true without its code");
  chk_range_bound: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_RANGE_SIGNED) |-> (cyc_min_q == 6'h02 && cyc_max_q == 6'h04))
    else $error("range check timing wrong");
  chk_dev_time: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && pfx_q[7:0] == 8'h2f && byte_in == 8'hf5) |=> (op_q == SOD_DEV_STORE_WORD && cyc_max_q == 6'h03))
    else $error("device store decode wrong");
  chk_restart_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_RESTART) |-> cyc_max_q == 6'h13)
    else $error("restart timing wrong");
  chk_trap_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_TRAP_RETURN) |-> cyc_min_q == 6'h09)
    else $error("trap return timing wrong");
  chk_bank_field: assert property (@(posedge clock) disable iff (rst)
    ##1 bank_q == $past(op_addr[31:30]))
    else $error("bank select wrong");
  chk_periph_route: assert property (@(posedge clock) disable iff (rst)
    to_periph_q |-> ($past(op_addr[31:29]) == 3'h1 && !to_ext_q))
    else $error("peripheral route wrong");
  chk_prefix_clear: assert property (@(posedge clock) disable iff (rst)
    issue_q |-> pfx_q == 16'h0000)
    else $error("prefix not cleared");
  // Timing table rows not covered above
  chk_block_setup: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_BLOCK2D_SETUP) |-> (cyc_min_q == 6'h01 && cyc_max_q == 6'h01))
    else $error("block setup timing wrong");
  chk_block_copy: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && pfx_q[7:0] == 8'h25 && byte_in == 8'hfc) |=> (issue_q && op_q == SOD_BLOCK2D_COPY_ALL))
    else $error("block copy decode wrong");
  chk_crc_byte_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_CRC_BYTE) |-> (cyc_min_q == 6'h0a && cyc_max_q == 6'h0a))
    else $error("crc byte timing wrong");
  chk_bitrev_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_BIT_REV_NBITS) |-> (cyc_min_q == 6'h02 && cyc_max_q == 6'h02))
    else $error("bit reverse timing wrong");
  chk_postnorm_span: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_FP_POSTNORM) |-> (cyc_min_q == 6'h07 && cyc_max_q == 6'h08))
    else $error("post normalize timing wrong");
  chk_fpu_need: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_FP_TEST_ERR) |-> fp_true_q)
    else $error("fp true missing");
  chk_sext_byte_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_SEXT_BYTE) |-> (cyc_min_q == 6'h03 && cyc_max_q == 6'h03))
    else $error("byte sign extend timing wrong");
  chk_half_store_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_HALF_STORE) |-> (cyc_min_q == 6'h02 && cyc_max_q == 6'h02))
    else $error("halfword store timing wrong");
  chk_queue_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && op_q == SOD_Q_INSERT) |-> (cyc_min_q == 6'h01 && cyc_max_q == 6'h02))
    else $error("queue insert timing wrong");
  chk_trap_ls_time: assert property (@(posedge clock) disable iff (rst)
    (issue_q && (op_q == SOD_TRAP_LOAD_HANDLER || op_q == SOD_TRAP_STORE_HANDLER)) |-> cyc_max_q == 6'h0b)
    else $error("trap load store timing wrong");
  // Address fields follow the operand one cycle late
  chk_word_split: assert property (@(posedge clock) disable iff (rst)
    ##1 (word_addr_q == $past(op_addr[31:2]) && byte_sel_q == $past(op_addr[1:0])))
    else $error("word split wrong");
  chk_pin_field: assert property (@(posedge clock) disable iff (rst)
    ##1 pin_addr_q == $past(op_addr[19:0]))
    else $error("pin address wrong");
  chk_route_one: assert property (@(posedge clock) disable iff (rst)
    issue_q |-> (to_periph_q != to_ext_q))
    else $error("route not exactly one");
  chk_ext_route: assert property (@(posedge clock) disable iff (rst)
    to_ext_q |-> (issue_q && !to_periph_q))
    else $error("external route wrong");
  chk_periph_dev: assert property (@(posedge clock) disable iff (rst)
    to_periph_q |-> is_dev(op_q))
    else $error("peripheral route without device op");
  // Prefix bytes never issue; final bytes always do
  chk_issue_pulse: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && byte_in[7:4] != 4'h2 && byte_in[7:4] != 4'h6) |=> issue_q)
    else $error("final byte not issued");
  chk_prefix_quiet: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && (byte_in[7:4] == 4'h2 || byte_in[7:4] == 4'h6)) |=> !issue_q)
    else $error("prefix byte issued");
  chk_prefix_shift: assert property (@(posedge clock) disable iff (rst)
    (byte_valid && byte_in[7:4] == 4'h2) |=> pfx_q[7:0] == $past(byte_in))
    else $error("prefix not accumulated");
endmodule
`default_nettype wire

//--- sod_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Fetch side stand-in: hands the decoder one byte a cycle
module sod_fetch_model (
  // Clock
  input  wire logic        clock,
  // Byte stream and operand
  output logic             byte_valid,
  output logic [7:0]       byte_in,
  output logic [31:0]      op_addr
);
  initial begin
    byte_valid = 1'b0;
    byte_in    = 8'h00;
    op_addr    = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // Caller sits just after a rising edge
  task automatic put(input logic [7:0] b);
    byte_valid = 1'b1;
    byte_in    = b;
    @(posedge clock);
    #1;
  endtask
  // Idle bus inverts the last byte every cycle, so stale data never looks valid
  task automatic rest(input int cycles);
    byte_valid = 1'b0;
    repeat (cycles) begin
      byte_in = ~byte_in;
      @(posedge clock);
      #1;
    end
  endtask
  // prefix bytes, then the final byte
  // Valid stays up into a back-to-back call, so no signal is set twice in one step
  task automatic send(input logic [15:0] code, input logic [31:0] addr, input logic [7:0] pre, input int gap);
    if (pre != 8'h00) begin
      put(pre);
    end
    put(code[15:8]);
    op_addr = addr;
    put(code[7:0]);
    if (gap != 0) begin
      rest(gap);
    end
  endtask
endmodule
`default_nettype wire

//--- secondary_op_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module secondary_op_decoder_test;
  import sod_pkg::*;
  typedef struct { logic [15:0] c; sod_op_t op; int lo; int hi; } sod_exp_t;
  typedef struct { sod_op_t op; int lo; int hi; logic fp; logic per; logic [31:0] a; } sod_note_t;
  logic             clock;
  logic             rst;
  logic             byte_valid;
  logic [7:0]       byte_in;
  logic [31:0]      op_addr;
  sod_op_t          op_q;
  logic             issue_q;
  logic [5:0]       cyc_min_q;
  logic [5:0]       cyc_max_q;
  logic             fp_true_q;
  logic [29:0]      word_addr_q;
  logic [1:0]       byte_sel_q;
  logic [1:0]       bank_q;
  logic [19:0]      pin_addr_q;
  logic             to_periph_q;
  logic             to_ext_q;
  int               bad_count = 0;
  int               check_count = 0;
  sod_note_t        notes[$];
  sod_note_t        n;
  // Zero cycles stands for data dependent; last entry is an unknown code
  sod_exp_t tbl[48] = '{
    '{'h25fb,SOD_BLOCK2D_SETUP,1,1}, '{'h25fc,SOD_BLOCK2D_COPY_ALL,0,0},
    '{'h25fd,SOD_BLOCK2D_COPY_NONZERO_BYTES,0,0}, '{'h25fe,SOD_BLOCK2D_COPY_ZERO_BYTES,0,0},
    '{'h27f4,SOD_CRC_WORD,34,34}, '{'h27f5,SOD_CRC_BYTE,10,10}, '{'h27f6,SOD_BIT_COUNT,3,3},
    '{'h27f7,SOD_BIT_REV_WORD,1,1}, '{'h27f8,SOD_BIT_REV_NBITS,2,2}, '{'h27f3,SOD_FP_CHECK_ERR,2,2},
    '{'h29fc,SOD_FP_TEST_ERR,1,1}, '{'h26f3,SOD_FP_UNPACK,4,4}, '{'h26fd,SOD_FP_ROUND,7,7},
    '{'h26fc,SOD_FP_POSTNORM,7,8}, '{'h2cf7,SOD_RANGE_SIGNED,2,4}, '{'h2cfc,SOD_RANGE_UNSIGNED,2,4},
    '{'h2bfa,SOD_BYTE_RANGE_CHECK,2,3}, '{'h2bfb,SOD_BYTE_RANGE_CHECK_U,2,3},
    '{'h2ffa,SOD_HALF_RANGE_CHECK,2,3}, '{'h2ffb,SOD_HALF_RANGE_CHECK_U,2,3},
    '{'h2ff8,SOD_SEXT_HALF,2,2}, '{'h2bf8,SOD_SEXT_BYTE,3,3}, '{'h2cf1,SOD_HALF_SUBSCRIPT,1,1},
    '{'h2cfa,SOD_HALFWORD_LOAD,1,1}, '{'h2cf8,SOD_HALF_STORE,2,2}, '{'h2bf9,SOD_LOAD_BYTE_SX,1,1},
    '{'h2ff9,SOD_LOAD_HALF_SX,1,1}, '{'h2ff0,SOD_DEV_LOAD_BYTE,3,3}, '{'h2ff2,SOD_DEV_LOAD_HALF,3,3},
    '{'h2ff4,SOD_DEV_LOAD_WORD,3,3}, '{'h2ff1,SOD_DEV_STORE_BYTE,3,3}, '{'h2ff3,SOD_DEV_STORE_HALF,3,3},
    '{'h2ff5,SOD_DEV_STORE_WORD,3,3}, '{'h62f4,SOD_DEV_BLOCK,0,0}, '{'h60f0,SOD_Q_SWAP,3,3},
    '{'h60f1,SOD_Q_SWAP_TIMER,5,5}, '{'h60f2,SOD_Q_INSERT,1,2}, '{'h60f3,SOD_TIMESLICE,3,4},
    '{'h62fe,SOD_RESTART,19,19}, '{'h62ff,SOD_CAUSE_ERR,2,2}, '{'h26fe,SOD_TRAP_LOAD_HANDLER,11,11},
    '{'h2cf6,SOD_TRAP_LOAD_PROC,11,11}, '{'h2cfb,SOD_TRAP_STORE_PROC,11,11},
    '{'h26ff,SOD_TRAP_STORE_HANDLER,11,11}, '{'h60f7,SOD_TRAP_ENABLE,2,2},
    '{'h60f6,SOD_TRAP_DISABLE,2,2}, '{'h60fb,SOD_TRAP_RETURN,9,9}, '{'h63f0,SOD_NONE,0,0}};

  initial clock = 1'b0;
  always #5 clock = ~clock;

  sod_fetch_model fm (.clock(clock), .byte_valid(byte_valid), .byte_in(byte_in), .op_addr(op_addr));

  sod_decoder dut (
    .clock(clock), .rst(rst), .byte_valid(byte_valid), .byte_in(byte_in), .op_addr(op_addr),
    .op_q(op_q), .issue_q(issue_q), .cyc_min_q(cyc_min_q), .cyc_max_q(cyc_max_q), .fp_true_q(fp_true_q),
    .word_addr_q(word_addr_q), .byte_sel_q(byte_sel_q), .bank_q(bank_q), .pin_addr_q(pin_addr_q),
    .to_periph_q(to_periph_q), .to_ext_q(to_ext_q)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Issue pulse is settled by the falling edge
  always @(negedge clock) begin
    if (issue_q === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare_issue", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        check("op", op_q, n.op);
        check("cyc_min", cyc_min_q, n.lo[5:0]);
        check("cyc_max", cyc_max_q, n.hi[5:0]);
        check("fp_true", fp_true_q, n.fp);
        check("word_addr", word_addr_q, n.a[31:2]);
        check("byte_sel", byte_sel_q, n.a[1:0]);
        check("bank", bank_q, n.a[31:30]);
        check("pin_addr", pin_addr_q, n.a[19:0]);
        check("to_periph", to_periph_q, n.per);
        check("to_ext", to_ext_q, !n.per);
      end
    end
  end

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int p;
    logic [31:0] a;
    logic [7:0] pre;
    logic dev;
    rst = 1'b1;
    void'($urandom(52676));
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    // Random, then the edges of the peripheral window, then just outside it
    for (p = 0; p < 3; p++) begin
      for (i = 0; i < 48; i++) begin
        a = $urandom;
        if (p == 1) a = {3'h1, i[0] ? 29'h1fff_ffff : 29'h000_0000};
        if (p == 2) a = i[0] ? 32'h4000_0000 : 32'h1fff_ffff;
        pre = ($urandom_range(3) == 0) ? 8'h26 : 8'h00;
        dev = (tbl[i].c >= 16'h2ff0 && tbl[i].c <= 16'h2ff5) || tbl[i].c == 16'h62f4;
        notes.push_back('{tbl[i].op, tbl[i].lo, tbl[i].hi, tbl[i].c == 16'h29fc, dev && a[31:29] == 3'h1, a});
        fm.send(tbl[i].c, a, pre, $urandom_range(2));
      end
    end
    fm.rest(2);
    for (i = 0; i < 20 && notes.size() != 0; i++) begin
      @(posedge clock);
    end
    if (notes.size() != 0) begin
      $display("BAD pending expected 0 seen %0d", notes.size());
      bad_count++;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
